// ==== hdl/logic_block.sv ====
// logic block: term arrays, control terms, 16 macrocells, pin buffers, register bus
// Overview of operation
// RL1: takes 36 array inputs, has 16 macrocells
// RL2: returns 32 feedback signals to the array
// RL3: six control terms, each and or or
// RL4: five own and terms per macrocell, fixed or
// RL5: 32 shared terms via programmable or, 37 max
// RL6: one shared term may feed many outputs
// RL7: macrocell is d, toggle or combinational
// RL8: clock from one of four sources
// RL9: first global clock comes from outside only
// RL10: second global clock from pin or macrocell
// RL11: rising or falling edge per macrocell
// RL12: clock control terms formed over 36 inputs
// RL13: first terms drive preset and reset
// RL14: power-on reset leaves registers at zero
// RL15: per macrocell preset/reset disable option
// RL16: output enable from control terms three..six
// RL17: output buffer fixed on or off
// RL18: global tristate pin low floats all outputs; here only while blk_cfg.gts_enable is set
// RL19: macrocell and pin feedback per macrocell
// RL20: input pin feeds array, buried logic still returns
// RL21: toggle register inverts when input high
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module logic_block
  import plb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [11:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [31:0] avm_writedata_i,
  input wire logic [3:0] avm_byteenable_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  input wire logic [N_IN-1:0] central_interconnect_array_i,
  input wire logic global_sync_clock_i,
  input wire logic global_dual_use_clock_i,
  input wire logic global_tristate_pin_n_i,
  input wire logic [N_MC-1:0] pin_i,
  output logic [N_MC-1:0] pin_o,
  output logic [N_MC-1:0] pin_oe_o,
  output logic [N_FB-1:0] feedback_o
);
  mc_cfg_t mc_cfg [N_MC];
  logic [N_PLA-1:0] pla_or_sel [N_MC];
  blk_cfg_t blk_cfg;
  logic [N_MC-1:0] mc_state;
  logic [N_MC-1:0] mc_value;
  logic [N_MC-1:0] mc_d;
  logic [N_MC-1:0] mc_edge;
  logic [N_MC-1:0] mc_oe;
  logic [N_MC-1:0] next_state;
  logic [N_TERMS-1:0] term_and;
  logic [N_TERMS-1:0] term_or;
  logic [N_CT-1:0] ct;
  logic [3:0] clk_src;
  logic [3:0] clk_src_q;
  logic dual_clk;
  logic rd_done;
  logic rd_from_bank;
  logic [31:0] local_rdata;
  logic [31:0] bank_rdata;
  logic in_terms;
  logic wr_go;
  logic [31:0] wr_merged;

  // =========================================================
  // register bus
  // reads take one wait state because the bank answers from a register
  assign avm_waitrequest_o = ~ce_i | (avm_read_i & ~rd_done);
  assign wr_go = avm_write_i & ce_i;
  assign in_terms = avm_address_i < TERM_REGION_END;
  assign avm_readdata_o = rd_from_bank ? bank_rdata : local_rdata;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_done <= 1'b0;
      rd_from_bank <= 1'b0;
    end else if (ce_i) begin
      rd_done <= avm_read_i & ~rd_done;
      if (avm_read_i && !rd_done) begin
        rd_from_bank <= in_terms;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      local_rdata <= 32'h0000_0000;
    end else if (ce_i && avm_read_i && !rd_done) begin
      local_rdata <= 32'h0000_0000;
      if (avm_address_i >= MC_CFG_BASE && avm_address_i < PLA_OR_BASE) begin
        local_rdata <= {23'h00_0000, mc_cfg[avm_address_i[5:2]]};
      end else if (avm_address_i >= PLA_OR_BASE && avm_address_i < BLK_CFG_ADDR) begin
        local_rdata <= pla_or_sel[avm_address_i[5:2]];
      end else if (avm_address_i == BLK_CFG_ADDR) begin
        local_rdata <= {16'h0000, blk_cfg};
      end else if (avm_address_i == MC_STATE_ADDR) begin
        local_rdata <= {16'h0000, mc_value};
      end else if (avm_address_i == PIN_STATE_ADDR) begin
        local_rdata <= {pin_oe_o, pin_i};
      end
    end
  end

  assign wr_merged = merge_be(32'h0000_0000, avm_writedata_i, avm_byteenable_i);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      blk_cfg <= BLK_CFG_RESET;
    end else if (wr_go && avm_address_i == BLK_CFG_ADDR) begin
      blk_cfg <= 16'(merge_be({16'h0000, blk_cfg}, avm_writedata_i, avm_byteenable_i)
                     & 32'h0000_F33F);
    end
  end

  // =========================================================
  // term arrays
  term_bank u_bank (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(wr_go & in_terms),
    .term_i(avm_address_i[10:4]),
    .word_i(avm_address_i[3:2]),
    .wr_data_i(avm_writedata_i),
    .wr_be_i(avm_byteenable_i),
    .rd_en_i(avm_read_i & ~rd_done & in_terms),
    .rd_data_o(bank_rdata),
    .lit_i(central_interconnect_array_i), // RL1 RL12
    .and_o(term_and),
    .or_o(term_or)
  );

  // control terms pick and or or form
  for (genvar k = 0; k < N_CT; k++) begin : g_ct
    assign ct[k] = blk_cfg.ct_or_mode[k] ? term_or[CT_BASE + k] : term_and[CT_BASE + k]; // RL3
  end

  // =========================================================
  // clock sources
  // only the first global clock stays pin-driven; the second may come from a macrocell
  assign dual_clk = blk_cfg.global_dual_use_clock_from_mc ? mc_value[blk_cfg.global_dual_use_clock_src]
                                         : global_dual_use_clock_i; // RL10
  assign clk_src = {ct[CT_CLK_B], ct[CT_CLK_A], dual_clk, global_sync_clock_i}; // RL8 RL9 RL12

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      clk_src_q <= 4'h0;
    end else if (ce_i) begin
      clk_src_q <= clk_src;
    end
  end

  // =========================================================
  // macrocells
  for (genvar m = 0; m < N_MC; m++) begin : g_mc
    logic src_now;
    logic src_old;

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        mc_cfg[m] <= MC_CFG_RESET;
        pla_or_sel[m] <= '0;
      end else if (wr_go) begin
        if (avm_address_i == MC_CFG_BASE + 12'(4 * m)) begin
          mc_cfg[m] <= 9'(merge_be({23'h00_0000, mc_cfg[m]}, avm_writedata_i,
                                   avm_byteenable_i) & 32'h0000_01FF);
        end
        if (avm_address_i == PLA_OR_BASE + 12'(4 * m)) begin
          pla_or_sel[m] <= merge_be(pla_or_sel[m], avm_writedata_i, avm_byteenable_i);
        end
      end
    end

    // shared terms are ored in per output, so one term serves many
    assign mc_d[m] = (|term_and[m * N_PAL +: N_PAL]) // RL4
                     | (|(term_and[PLA_BASE +: N_PLA] & pla_or_sel[m])); // RL5 RL6

    assign src_now = clk_src[mc_cfg[m].clk_sel];
    assign src_old = clk_src_q[mc_cfg[m].clk_sel];
    assign mc_edge[m] = mc_cfg[m].clk_fall ? (src_old & ~src_now)
                                          : (~src_old & src_now); // RL11

    always_comb begin
      next_state[m] = mc_state[m];
      if (!mc_cfg[m].pr_disable && ct[CT_RESET]) begin // RL15
        next_state[m] = 1'b0; // RL13
      end else if (!mc_cfg[m].pr_disable && ct[CT_PRESET]) begin
        next_state[m] = 1'b1; // RL13
      end else if (mc_edge[m]) begin
        case (mc_cfg[m].mode)
          MODE_D: next_state[m] = mc_d[m]; // RL7
          MODE_T: next_state[m] = mc_state[m] ^ mc_d[m]; // RL21
          default: next_state[m] = mc_state[m];
        endcase
      end
    end

    assign mc_value[m] = (mc_cfg[m].mode == MODE_COMB) ? mc_d[m] : mc_state[m]; // RL7

    always_comb begin
      case (mc_cfg[m].oe_sel)
        OE_CT_CLOCK_A: mc_oe[m] = ct[CT_CLK_A]; // RL16
        OE_CT_CLOCK_B: mc_oe[m] = ct[CT_CLK_B];
        OE_CT_OE_A: mc_oe[m] = ct[CT_OE_A];
        OE_CT_OE_B: mc_oe[m] = ct[CT_OE_B];
        OE_ALWAYS_ON: mc_oe[m] = 1'b1; // RL17
        default: mc_oe[m] = 1'b0; // RL17
      endcase
    end
  end

  // preset and reset act as levels sampled on the system clock, not true async
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mc_state <= '0; // RL14
    end else if (ce_i) begin
      mc_state <= next_state;
    end
  end

  // =========================================================
  // pins and feedback
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      feedback_o <= '0;
    end else if (ce_i) begin
      pin_o <= mc_value;
      pin_oe_o <= (blk_cfg.gts_enable && !global_tristate_pin_n_i) ? '0 : mc_oe; // RL18
      feedback_o <= {pin_i, mc_value}; // RL2 RL19 RL20
    end
  end

  // =========================================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  mc_reset_term_a: assert property (ce_i && ct[CT_RESET] && !mc_cfg[0].pr_disable // RL13
                                    |=> mc_state[0] == 1'b0)
    else $error("reset term did not clear macrocell 0");
  mc_preset_term_a: assert property (ce_i && !ct[CT_RESET] && ct[CT_PRESET] // RL13
                                     && !mc_cfg[0].pr_disable |=> mc_state[0] == 1'b1)
    else $error("preset term did not set macrocell 0");
  pr_disable_a: assert property (ce_i && mc_cfg[0].pr_disable && !mc_edge[0] // RL15
                                 |=> $stable(mc_state[0]))
    else $error("disabled macrocell changed without clock edge");
  toggle_reg_a: assert property (ce_i && mc_cfg[0].mode == MODE_T && mc_edge[0] // RL21
                                 && mc_d[0] && !ct[CT_RESET] && !ct[CT_PRESET]
                                 |=> mc_state[0] != $past(mc_state[0]))
    else $error("toggle register did not invert");
  d_reg_a: assert property (ce_i && mc_cfg[0].mode == MODE_D && mc_edge[0] // RL7
                            && !ct[CT_RESET] && !ct[CT_PRESET]
                            |=> mc_state[0] == $past(mc_d[0]))
    else $error("d register did not load input");
  sync_clk_edge_a: assert property (ce_i && mc_cfg[0].clk_sel == CLK_SYNC // RL11
                                    && !mc_cfg[0].clk_fall
                                    ##1 ce_i && global_sync_clock_i && !$past(global_sync_clock_i)
                                    |-> mc_edge[0])
    else $error("rising sync clock edge missed");
  gts_float_a: assert property (ce_i && blk_cfg.gts_enable && !global_tristate_pin_n_i // RL18
                                |=> pin_oe_o == '0)
    else $error("global tristate did not float outputs");
  oe_off_a: assert property (ce_i && mc_cfg[0].oe_sel == OE_ALWAYS_OFF // RL17
                             |=> !pin_oe_o[0])
    else $error("output driven while fixed off");
  mc_feedback_a: assert property (ce_i |=> feedback_o[N_MC-1:0] == $past(mc_value)) // RL19
    else $error("macrocell feedback wrong");
  pin_feedback_a: assert property (ce_i |=> feedback_o[N_FB-1:N_MC] == $past(pin_i)) // RL20
    else $error("pin feedback wrong");
  bus_read_a: assert property (ce_i && avm_read_i && avm_waitrequest_o
                               ##1 ce_i && avm_read_i |-> !avm_waitrequest_o)
    else $error("read not answered after one wait");

  toggle_c: cover property (mc_cfg[0].mode == MODE_T && mc_edge[0] && mc_d[0]);
  gts_c: cover property (blk_cfg.gts_enable && !global_tristate_pin_n_i);
  ct_clock_c: cover property (mc_cfg[1].clk_sel == CLK_CT_A && mc_edge[1]);
  dual_mc_clock_c: cover property (blk_cfg.global_dual_use_clock_from_mc && mc_edge[2]);
endmodule : logic_block

// ==== hdl/term_bank.sv ====
// term bank: literal masks of every and/or term, evaluation and registered readback
`timescale 1ns/1ps
module term_bank
  import plb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [TERM_W-1:0] term_i,
  input wire logic [1:0] word_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [3:0] wr_be_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  input wire logic [N_IN-1:0] lit_i,
  output logic [N_TERMS-1:0] and_o,
  output logic [N_TERMS-1:0] or_o
);
  logic [N_IN-1:0] true_mask [N_TERMS];
  logic [N_IN-1:0] comp_mask [N_TERMS];

  // =========================================================
  // per term storage and evaluation
  for (genvar t = 0; t < N_TERMS; t++) begin : g_term
    logic [31:0] high_word;
    logic [31:0] high_new;
    assign high_word = {24'h00_0000, comp_mask[t][35:32], true_mask[t][35:32]};
    assign high_new = merge_be(high_word, wr_data_i, wr_be_i);

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        true_mask[t] <= '0;
        comp_mask[t] <= '0;
      end else if (ce_i && wr_en_i && term_i == TERM_W'(t)) begin
        case (word_i)
          WORD_TRUE: true_mask[t][31:0] <= merge_be(true_mask[t][31:0], wr_data_i, wr_be_i);
          WORD_COMP: comp_mask[t][31:0] <= merge_be(comp_mask[t][31:0], wr_data_i, wr_be_i);
          WORD_HIGH: begin
            true_mask[t][35:32] <= high_new[HIGH_TRUE_POS +: 4];
            comp_mask[t][35:32] <= high_new[HIGH_COMP_POS +: 4];
          end
          default: ;
        endcase
      end
    end

    // an empty term reads low, so an unprogrammed block drives nothing
    assign and_o[t] = (|(true_mask[t] | comp_mask[t]))
                      & (&((~true_mask[t] | lit_i) & (~comp_mask[t] | ~lit_i)));
    assign or_o[t] = |((true_mask[t] & lit_i) | (comp_mask[t] & ~lit_i));
  end

  // =========================================================
  // readback
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (ce_i && rd_en_i) begin
      if (int'(term_i) >= N_TERMS) begin
        rd_data_o <= 32'h0000_0000;
      end else begin
        case (word_i)
          WORD_TRUE: rd_data_o <= true_mask[term_i][31:0];
          WORD_COMP: rd_data_o <= comp_mask[term_i][31:0];
          WORD_HIGH: rd_data_o <= {24'h00_0000, comp_mask[term_i][35:32],
                                   true_mask[term_i][35:32]};
          default: rd_data_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : term_bank

// ==== pkg/plb_pkg.sv ====
// package: sizes, register map, field layouts and encodings of the logic block
package plb_pkg;
  // =========================================================
  // block sizes
  localparam int N_IN = 36;
  localparam int N_MC = 16;
  localparam int N_PAL = 5;
  localparam int N_PLA = 32;
  localparam int N_CT = 6;
  localparam int N_FB = 32;
  localparam int PLA_BASE = N_MC * N_PAL;
  localparam int CT_BASE = PLA_BASE + N_PLA;
  localparam int N_TERMS = CT_BASE + N_CT;
  localparam int TERM_W = 7;
  // =========================================================
  // register map, byte addresses
  localparam logic [11:0] TERM_REGION_END = 12'h760;
  localparam logic [11:0] MC_CFG_BASE = 12'h800;
  localparam logic [11:0] PLA_OR_BASE = 12'h840;
  localparam logic [11:0] BLK_CFG_ADDR = 12'h880;
  localparam logic [11:0] MC_STATE_ADDR = 12'h884;
  localparam logic [11:0] PIN_STATE_ADDR = 12'h888;
  // term word layout: 0 true mask, 1 complement mask, 2 upper literals
  localparam logic [1:0] WORD_TRUE = 2'h0;
  localparam logic [1:0] WORD_COMP = 2'h1;
  localparam logic [1:0] WORD_HIGH = 2'h2;
  localparam int HIGH_TRUE_POS = 0;
  localparam int HIGH_COMP_POS = 4;
  // =========================================================
  // macrocell configuration
  localparam logic [1:0] MODE_D = 2'h0;
  localparam logic [1:0] MODE_T = 2'h1;
  localparam logic [1:0] MODE_COMB = 2'h2;
  localparam logic [1:0] CLK_SYNC = 2'h0;
  localparam logic [1:0] CLK_DUAL = 2'h1;
  localparam logic [1:0] CLK_CT_A = 2'h2;
  localparam logic [1:0] CLK_CT_B = 2'h3;
  localparam logic [2:0] OE_CT_CLOCK_A = 3'h0;
  localparam logic [2:0] OE_CT_CLOCK_B = 3'h1;
  localparam logic [2:0] OE_CT_OE_A = 3'h2;
  localparam logic [2:0] OE_CT_OE_B = 3'h3;
  localparam logic [2:0] OE_ALWAYS_ON = 3'h4;
  localparam logic [2:0] OE_ALWAYS_OFF = 3'h5;
  // control term indices
  localparam int CT_PRESET = 0;
  localparam int CT_RESET = 1;
  localparam int CT_CLK_A = 2;
  localparam int CT_CLK_B = 3;
  localparam int CT_OE_A = 4;
  localparam int CT_OE_B = 5;

  typedef struct packed {
    logic [2:0] oe_sel;
    logic pr_disable;
    logic clk_fall;
    logic [1:0] clk_sel;
    logic [1:0] mode;
  } mc_cfg_t;

  typedef struct packed {
    logic [3:0] global_dual_use_clock_src;
    logic [1:0] rsv1;
    logic global_dual_use_clock_from_mc;
    logic gts_enable;
    logic [1:0] rsv0;
    logic [5:0] ct_or_mode;
  } blk_cfg_t;

  localparam mc_cfg_t MC_CFG_RESET = '{OE_ALWAYS_OFF, 1'b0, 1'b0, CLK_SYNC, MODE_D};
  localparam blk_cfg_t BLK_CFG_RESET = '0;

  // byte-lane merge for the register bus
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge_be
endpackage : plb_pkg

// ==== testbench/board_model.sv ====
// board model: clock pins, tristate pin and resolved pin wires
`timescale 1ns/1ps
module board_model (
  input wire logic clock_i,
  input wire logic sync_lvl_i,
  input wire logic dual_lvl_i,
  input wire logic gts_n_i,
  input wire logic [15:0] drv_en_i,
  input wire logic [15:0] drv_val_i,
  input wire logic [15:0] dev_val_i,
  input wire logic [15:0] dev_oe_i,
  output logic sync_clk_o,
  output logic dual_clk_o,
  output logic gts_n_o,
  output logic [15:0] pin_o
);
  logic [15:0] last = '0;
  // ==========
  // clocks and tristate come from outside the device
  assign sync_clk_o = sync_lvl_i;
  assign dual_clk_o = dual_lvl_i;
  assign gts_n_o = gts_n_i;
  // an undriven pin flips, so a stale level never passes for data
  assign pin_o = (dev_oe_i & dev_val_i) | (~dev_oe_i & drv_en_i & drv_val_i)
    | (~dev_oe_i & ~drv_en_i & ~last);
  always_ff @(posedge clock_i) begin
    last <= pin_o;
  end
endmodule : board_model

// ==== testbench/logic_block_tb.sv ====
// testbench of the logic block: bus tasks, random and corner scenarios
`timescale 1ns/1ps
module logic_block_tb
  import plb_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] avm_address_i = '0;
  logic avm_read_i = 1'b0;
  logic avm_write_i = 1'b0;
  logic [31:0] avm_writedata_i = '0;
  logic [31:0] avm_readdata_o, q, fb;
  logic avm_waitrequest_o, sclk, dclk, gts_w;
  logic [35:0] cia = '0;
  logic sync_lvl = 1'b0;
  logic gts_n = 1'b1;
  logic [15:0] drv_en = '0;
  logic [15:0] drv_val = '0;
  logic [15:0] pin_w, pin_o, pin_oe, e;
  int failures = 0;
  int check_count = 0;
  int seed = 4237;

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  logic_block uut (.clock_i, .rst_i, .ce_i(1'b1), .avm_address_i, .avm_read_i,
    .avm_write_i, .avm_writedata_i, .avm_byteenable_i(4'hF), .avm_readdata_o,
    .avm_waitrequest_o, .central_interconnect_array_i(cia), .global_sync_clock_i(sclk),
    .global_dual_use_clock_i(dclk), .global_tristate_pin_n_i(gts_w), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .feedback_o(fb));
  board_model board (.clock_i, .sync_lvl_i(sync_lvl), .dual_lvl_i(1'b0), .gts_n_i(gts_n),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .dev_val_i(pin_o), .dev_oe_i(pin_oe),
    .sync_clk_o(sclk), .dual_clk_o(dclk), .gts_n_o(gts_w), .pin_o(pin_w));

  // ==========
  // helpers
  task automatic wrap_up();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // one idle edge before each request keeps strobes single-assigned per step
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avm_address_i <= a;
    avm_writedata_i <= d;
    avm_write_i <= w;
    avm_read_i <= ~w;
    do begin
      @(posedge clock_i);
      n++;
    end while (avm_waitrequest_o !== 1'b0 && n < 40);
    q = avm_readdata_o;
    avm_write_i <= 1'b0;
    avm_read_i <= 1'b0;
    if (n >= 40) begin
      failures++;
      wrap_up();
    end
  endtask : bus

  task automatic term(input int t, input logic [35:0] m);
    bus(1'b1, 12'(t * 16), m[31:0]);
    bus(1'b1, 12'(t * 16 + 4), 32'h0000_0000);
    bus(1'b1, 12'(t * 16 + 8), {28'h000_0000, m[35:32]});
  endtask : term

  task automatic mc(input int m, input logic [2:0] oe, input logic [1:0] pf,
                    input logic [1:0] ck, input logic [1:0] md);
    bus(1'b1, MC_CFG_BASE + 12'(4 * m), {23'h00_0000, oe, pf, ck, md});
  endtask : mc

  task automatic st(input string nm, input logic [15:0] msk);
    bus(1'b0, MC_STATE_ADDR, 32'h0000_0000);
    check(nm, q & 32'(msk), 32'(e & msk));
  endtask : st

  task automatic pulse();
    sync_lvl <= 1'b1;
    tick(3);
    sync_lvl <= 1'b0;
    tick(3);
  endtask : pulse

  function automatic logic tog(input logic s, input logic d);
    return s ^ d;
  endfunction : tog

  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)}) & 36'h0_FFFF_FFFF;
  endfunction : rnd

  initial begin
    tick(10000);
    failures++;
    wrap_up();
  end

  // ==========
  // scenarios
  initial begin
    tick(3);
    rst_i <= 1'b0;
    bus(1'b0, MC_CFG_BASE, 32'h0000_0000);
    check("mc_cfg", q, 32'(MC_CFG_RESET));
    bus(1'b0, 12'hFFC, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    e = 16'h0000;
    st("por", 16'hFFFF);
    check("oe_rst", 32'(pin_oe), 32'h0000_0000);
    for (int m = 0; m < 16; m++) begin
      term(m * 5, 36'h1 << m);
      mc(m, OE_ALWAYS_ON, 2'b00, CLK_SYNC, MODE_D);
    end
    for (int k = 0; k < 4; k++) begin
      cia <= (k == 0) ? 36'h0_0000_FFFF : rnd();
      tick(2);
      pulse();
      e = cia[15:0];
      st("d_reg", 16'hFFFF);
      check("fb_mc", 32'(fb[15:0]), 32'(e));
      check("pin_o", 32'(pin_o), 32'(e));
      check("oe_on", 32'(pin_oe), 32'h0000_FFFF);
    end
    mc(0, OE_ALWAYS_ON, 2'b00, CLK_SYNC, MODE_T);
    for (int i = 0; i < 4; i++) begin
      cia[0] <= (i != 2);
      tick(1);
      pulse();
      e[0] = tog(e[0], i != 2);
      st("t_reg", 16'h0001);
    end
    mc(1, OE_ALWAYS_ON, 2'b01, CLK_SYNC, MODE_D);
    cia[1] <= ~e[1];
    tick(2);
    sync_lvl <= 1'b1;
    tick(3);
    st("rise_ign", 16'h0002);
    sync_lvl <= 1'b0;
    tick(3);
    e[1] = ~e[1];
    st("fall_cap", 16'h0002);
    mc(2, OE_ALWAYS_ON, 2'b00, CLK_SYNC, MODE_COMB);
    mc(3, OE_ALWAYS_ON, 2'b00, CLK_SYNC, MODE_COMB);
    cia[3:2] <= 2'b01;
    cia[20] <= 1'b0;
    tick(3);
    check("comb", 32'(pin_o[3:2]), 32'h0000_0001);
    // one shared term feeds two outputs
    term(PLA_BASE, 36'h1 << 20);
    bus(1'b1, PLA_OR_BASE + 12'h008, 32'h0000_0001);
    bus(1'b1, PLA_OR_BASE + 12'h00C, 32'h0000_0001);
    cia[3:2] <= 2'b00;
    cia[20] <= 1'b1;
    tick(3);
    check("shared", 32'(pin_o[3:2]), 32'h0000_0003);
    cia[20] <= 1'b0;
    tick(3);
    check("shared0", 32'(pin_o[3:2]), 32'h0000_0000);
    term(CT_BASE + CT_CLK_A, 36'h0_C000_0000);
    mc(4, OE_ALWAYS_ON, 2'b00, CLK_CT_A, MODE_D);
    for (int o = 0; o < 2; o++) begin
      cia[31:30] <= 2'b00;
      cia[4] <= ~e[4];
      tick(3);
      cia[30] <= 1'b1;
      tick(3);
      e[4] = (o == 1) ? ~e[4] : e[4];
      st("ct_one", 16'h0010);
      cia[31] <= 1'b1;
      tick(3);
      e[4] = (o == 0) ? ~e[4] : e[4];
      st("ct_both", 16'h0010);
      bus(1'b1, BLK_CFG_ADDR, 32'h0000_0004);
    end
    mc(5, OE_ALWAYS_ON, 2'b10, CLK_SYNC, MODE_D);
    term(CT_BASE + CT_PRESET, 36'h2_0000_0000);
    term(CT_BASE + CT_RESET, 36'h4_0000_0000);
    cia[33] <= 1'b1;
    tick(3);
    e[1:0] = 2'b11;
    st("preset", 16'h0023);
    cia[34] <= 1'b1;
    tick(3);
    e[1:0] = 2'b00;
    st("reset_win", 16'h0023);
    cia[34:33] <= 2'b00;
    for (int s = 0; s < 4; s++) begin
      term(CT_BASE + CT_CLK_A + s, 36'h8_0000_0000);
      mc(6, 3'(s), 2'b00, CLK_SYNC, MODE_D);
      cia[35] <= 1'b0;
      tick(3);
      check("oe_low", 32'(pin_oe[6]), 32'h0000_0000);
      cia[35] <= 1'b1;
      tick(3);
      check("oe_high", 32'(pin_oe[6]), 32'h0000_0001);
      term(CT_BASE + CT_CLK_A + s, 36'h0_0000_0000);
    end
    bus(1'b1, BLK_CFG_ADDR, 32'h0000_0100);
    gts_n <= 1'b0;
    tick(3);
    check("gts_off", 32'(pin_oe), 32'h0000_0000);
    gts_n <= 1'b1;
    tick(3);
    check("gts_on", 32'(pin_oe[0]), 32'h0000_0001);
    // second global clock taken from combinational macrocell 2
    bus(1'b1, BLK_CFG_ADDR, 32'h0000_2300);
    mc(8, OE_ALWAYS_ON, 2'b00, CLK_DUAL, MODE_D);
    cia[8] <= 1'b1;
    cia[2] <= 1'b0;
    tick(3);
    cia[2] <= 1'b1;
    tick(3);
    e[8] = 1'b1;
    st("dual_mc", 16'h0100);
    cia[2] <= 1'b0;
    // mc7 becomes an input pin, its register stays buried
    mc(7, OE_ALWAYS_OFF, 2'b00, CLK_SYNC, MODE_D);
    drv_en <= 16'h0080;
    for (int i = 0; i < 3; i++) begin
      drv_val <= 16'($random(seed));
      tick(3);
      check("pin_fb", 32'(fb[23]), 32'(drv_val[7]));
      check("buried", 32'(fb[7]), 32'h0000_0000);
      check("in_oe", 32'(pin_oe[7]), 32'h0000_0000);
    end
    wrap_up();
  end
endmodule : logic_block_tb
